// file: src/ssr_regs.svh
// Constants for the serial EEPROM status and instruction logic
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// Instruction opcodes
`define SSR_SET_WRITE_LATCH_CMD   8'h06
`define SSR_CLEAR_WRITE_LATCH_CMD 8'h04
`define SSR_READ_STATUS_CMD       8'h05
`define SSR_WRITE_STATUS_CMD      8'h01
`define SSR_READ_ARRAY_CMD        8'h03
`define SSR_WRITE_ARRAY_CMD       8'h02

// Status byte field positions
`define SSR_BUSY_FLAG_POS          0
`define SSR_WRITE_ENABLE_LATCH_POS 1
`define SSR_BLOCK_PROTECT_LO_POS   2
`define SSR_BLOCK_PROTECT_HI_POS   3
`define SSR_ZERO_FIELD_LO_POS      4
`define SSR_ZERO_FIELD_HI_POS      6
`define SSR_STATUS_LOCK_BIT_POS    7

// Reset values
`define SSR_BLOCK_PROTECT_RST      2'h0
`define SSR_STATUS_LOCK_RST        1'h0
`define SSR_WRITE_LATCH_RST        1'h0
`define SSR_CS_N_IDLE              1'h1

// Timing
`define SSR_NVM_CYCLE_TIME_NS      5000000
`define SSR_CLK_PERIOD_NS          4

`endif

// file: src/ssr_pkg.sv
// Types for the serial EEPROM status and instruction logic
package ssr_pkg;

  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_OPCODE  = 8'h02,
    S_WAITCS  = 8'h04,
    S_STAT_OUT = 8'h08,
    S_WSDATA  = 8'h10,
    S_WSARMED = 8'h20,
    S_ARRAY   = 8'h40,
    S_IGNORE  = 8'h80
  } ssr_state_t;

endpackage

// file: src/ssr_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
module ssr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1Reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1Reg <= RST_VAL;
      q         <= RST_VAL;
    end else if (ce) begin
      stage1Reg <= d;
      q         <= stage1Reg;
    end
  end

endmodule // ssr_sync

// file: src/ssr_eeprom_ctrl.sv
// Instruction decoder and status byte logic of a serial EEPROM
`include "ssr_regs.svh"

module ssr_eeprom_ctrl #(
  parameter int NVM_CYCLES = `SSR_NVM_CYCLE_TIME_NS / `SSR_CLK_PERIOD_NS
) (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Serial pins
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        wpN,
  output logic             miso,
  output logic             misoOe,
  // Array engine hand-off
  output logic             cmdArrayRead,
  output logic             cmdArrayWrite,
  input  wire logic        arrayWriteReq,
  input  wire logic [15:0] arrayWriteAddr,
  output logic             arrayWriteAck,
  // Status view
  output logic             busyFlag,
  output logic [1:0]       blockProtect,
  output logic             hardwareLockMode
);

  localparam int CW = $clog2(NVM_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection

  logic       csNS;
  logic       sclkS;
  logic       mosiS;
  logic       wpNS;
  logic       csNDly;
  logic       sclkDly;
  logic       sclkRise;
  logic       sclkFall;
  logic       csRise;
  logic       csFall;

  ssr_sync #(.WIDTH(4), .RST_VAL(4'h9)) uSync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({csN, sclk, mosi, wpN}),
    .q   ({csNS, sclkS, mosiS, wpNS})
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      csNDly  <= `SSR_CS_N_IDLE;
      sclkDly <= 1'h0;
    end else if (ce) begin
      csNDly  <= csNS;
      sclkDly <= sclkS;
    end
  end

  assign sclkRise = ce & ~csNS & sclkS & ~sclkDly;
  assign sclkFall = ce & ~csNS & ~sclkS & sclkDly;
  assign csRise   = ce & csNS & ~csNDly;
  assign csFall   = ce & ~csNS & csNDly;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register

  logic [2:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] rxByte;
  logic       byteDone;

  assign rxByte   = {shiftIn[6:0], mosiS};
  assign byteDone = sclkRise & (bitCnt == 3'h7);

  always_ff @(posedge clk) begin
    if (rst) begin
      bitCnt  <= 3'h0;
      shiftIn <= 8'h00;
    end else if (csFall) begin
      bitCnt  <= 3'h0;
    end else if (sclkRise) begin
      shiftIn <= rxByte;
      bitCnt  <= bitCnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status state

  ssr_pkg::ssr_state_t state;
  logic [7:0]          opReg;
  logic                weReg;
  logic                lockReg;
  logic [1:0]          bpReg;
  logic [1:0]          pendBp;
  logic                pendLock;
  logic                busyReg;
  logic                statusWrCycle;
  logic [CW-1:0]       cycleCnt;
  logic                cycleDone;
  logic                arrayStart;
  logic [7:0]          statusByte;

  function automatic logic inProtected(input logic [1:0] bp, input logic [15:0] addr);
    case (bp)
      2'h1:    inProtected = (addr[15:14] == 2'h3);
      2'h2:    inProtected = addr[15];
      2'h3:    inProtected = 1'h1;
      default: inProtected = 1'h0;
    endcase
  endfunction

  always_comb begin
    statusByte                                                  = 8'h00;
    statusByte[`SSR_BUSY_FLAG_POS]                              = busyReg;
    statusByte[`SSR_WRITE_ENABLE_LATCH_POS]                     = weReg;
    statusByte[`SSR_BLOCK_PROTECT_HI_POS:`SSR_BLOCK_PROTECT_LO_POS] = bpReg;
    statusByte[`SSR_STATUS_LOCK_BIT_POS]                        = lockReg;
  end

  assign cycleDone = ce & busyReg & (cycleCnt == CW'(0));
  assign arrayStart = ce & arrayWriteReq & weReg & ~busyReg
                      & ~inProtected(bpReg, arrayWriteAddr);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction sequencer

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ssr_pkg::S_IDLE;
      opReg <= 8'h00;
    end else if (ce) begin
      if (csRise) begin
        state <= ssr_pkg::S_IDLE;
      end else if (csFall) begin
        state <= ssr_pkg::S_OPCODE;
      end else if (byteDone && state == ssr_pkg::S_OPCODE) begin
        opReg <= rxByte;
        case (rxByte)
          `SSR_SET_WRITE_LATCH_CMD,
          `SSR_CLEAR_WRITE_LATCH_CMD: begin
            state <= busyReg ? ssr_pkg::S_IGNORE : ssr_pkg::S_WAITCS;
          end
          `SSR_READ_STATUS_CMD: begin
            state <= ssr_pkg::S_STAT_OUT;
          end
          `SSR_WRITE_STATUS_CMD: begin
            if (!weReg || hardwareLockMode || busyReg) begin
              state <= ssr_pkg::S_IGNORE;
            end else begin
              state <= ssr_pkg::S_WSDATA;
            end
          end
          `SSR_READ_ARRAY_CMD,
          `SSR_WRITE_ARRAY_CMD: begin
            state <= busyReg ? ssr_pkg::S_IGNORE : ssr_pkg::S_ARRAY;
          end
          default: begin
            state <= ssr_pkg::S_IGNORE;
          end
        endcase
      end else if (byteDone && state == ssr_pkg::S_WSDATA) begin
        state <= ssr_pkg::S_WSARMED;
      end else if (sclkRise && state == ssr_pkg::S_WSARMED) begin
        state <= ssr_pkg::S_IGNORE;
      end
    end
  end

  // Pending status values
  always_ff @(posedge clk) begin
    if (rst) begin
      pendBp   <= `SSR_BLOCK_PROTECT_RST;
      pendLock <= `SSR_STATUS_LOCK_RST;
    end else if (byteDone && state == ssr_pkg::S_WSDATA) begin
      pendBp   <= rxByte[`SSR_BLOCK_PROTECT_HI_POS:`SSR_BLOCK_PROTECT_LO_POS];
      pendLock <= rxByte[`SSR_STATUS_LOCK_BIT_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write cycle

  always_ff @(posedge clk) begin
    if (rst) begin
      busyReg   <= 1'h0;
      statusWrCycle <= 1'h0;
      cycleCnt  <= CW'(0);
    end else if (ce) begin
      if (csRise && state == ssr_pkg::S_WSARMED) begin
        busyReg   <= 1'h1;
        statusWrCycle <= 1'h1;
        cycleCnt  <= CW'(NVM_CYCLES - 1);
      end else if (arrayStart) begin
        busyReg   <= 1'h1;
        statusWrCycle <= 1'h0;
        cycleCnt  <= CW'(NVM_CYCLES - 1);
      end else if (cycleDone) begin
        busyReg   <= 1'h0;
        statusWrCycle <= 1'h0;
      end else if (busyReg) begin
        cycleCnt  <= cycleCnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bpReg   <= `SSR_BLOCK_PROTECT_RST;
      lockReg <= `SSR_STATUS_LOCK_RST;
    end else if (cycleDone && statusWrCycle) begin
      bpReg   <= pendBp;
      lockReg <= pendLock;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      weReg <= `SSR_WRITE_LATCH_RST;
    end else if (ce) begin
      if (cycleDone) begin
        weReg <= 1'h0;
      end else if (csRise && state == ssr_pkg::S_WAITCS) begin
        weReg <= (opReg == `SSR_SET_WRITE_LATCH_CMD);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  logic [2:0] outIdx;
  logic [7:0] txByte;

  always_ff @(posedge clk) begin
    if (rst) begin
      outIdx <= 3'h7;
      txByte <= 8'h00;
      miso   <= 1'h0;
    end else if (ce) begin
      if (byteDone && state == ssr_pkg::S_OPCODE) begin
        outIdx <= 3'h7;
      end else if (sclkFall && state == ssr_pkg::S_STAT_OUT) begin
        if (outIdx == 3'h7) begin
          txByte <= statusByte;
          miso   <= statusByte[7];
        end else begin
          miso   <= txByte[outIdx];
        end
        outIdx <= outIdx - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      misoOe <= 1'h0;
    end else if (ce) begin
      misoOe <= (state == ssr_pkg::S_STAT_OUT) & ~csNS & ~csRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand-off and status outputs

  always_ff @(posedge clk) begin
    if (rst) begin
      cmdArrayRead     <= 1'h0;
      cmdArrayWrite    <= 1'h0;
      arrayWriteAck    <= 1'h0;
      busyFlag         <= 1'h0;
      blockProtect     <= `SSR_BLOCK_PROTECT_RST;
      hardwareLockMode <= 1'h0;
    end else if (ce) begin
      cmdArrayRead     <= byteDone && state == ssr_pkg::S_OPCODE && !busyReg
                          && rxByte == `SSR_READ_ARRAY_CMD;
      cmdArrayWrite    <= byteDone && state == ssr_pkg::S_OPCODE && !busyReg
                          && rxByte == `SSR_WRITE_ARRAY_CMD;
      arrayWriteAck    <= arrayStart;
      busyFlag         <= busyReg;
      blockProtect     <= bpReg;
      hardwareLockMode <= lockReg & ~wpNS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_inv_ignore;
    @(posedge clk) disable iff (rst)
    (byteDone && state == ssr_pkg::S_OPCODE && !csRise && rxByte[7:2] != 6'h00
     && rxByte != 8'h04 && rxByte != 8'h05 && rxByte != 8'h06)
    |=> state == ssr_pkg::S_IGNORE;
  endproperty
  a_inv_ignore: assert property (p_inv_ignore) else $error("bad opcode not ignored");

  property p_wel_done;
    @(posedge clk) disable iff (rst)
    cycleDone |=> !weReg && !busyReg;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch or busy not cleared");

  property p_busy_len;
    @(posedge clk) disable iff (rst)
    (ce && !busyReg && csRise && state == ssr_pkg::S_WSARMED) |=> busyReg [*2];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy not held");

  property p_wel_gate;
    @(posedge clk) disable iff (rst)
    (byteDone && state == ssr_pkg::S_OPCODE && !csRise && !weReg
     && rxByte == `SSR_WRITE_STATUS_CMD) |=> state == ssr_pkg::S_IGNORE;
  endproperty
  a_wel_gate: assert property (p_wel_gate) else $error("status write without latch");

  property p_hw_lock;
    @(posedge clk) disable iff (rst)
    (byteDone && state == ssr_pkg::S_OPCODE && !csRise && hardwareLockMode
     && rxByte == `SSR_WRITE_STATUS_CMD) |=> state != ssr_pkg::S_WSDATA;
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("locked status write taken");

  property p_bp_frozen;
    @(posedge clk) disable iff (rst)
    (busyReg && !cycleDone) |=> $stable(bpReg) && $stable(lockReg);
  endproperty
  a_bp_frozen: assert property (p_bp_frozen) else $error("protect changed mid cycle");

  property p_status_map;
    @(posedge clk) disable iff (rst)
    statusByte[6:4] == 3'h0 && statusByte[0] == busyReg && statusByte[1] == weReg;
  endproperty
  a_status_map: assert property (p_status_map) else $error("status layout wrong");

  property p_oe_off;
    @(posedge clk) disable iff (rst)
    (ce && csNS) |=> !misoOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output on while deselected");

  property p_armed_cancel;
    @(posedge clk) disable iff (rst)
    (sclkRise && state == ssr_pkg::S_WSARMED && !csRise) |=> state == ssr_pkg::S_IGNORE;
  endproperty
  a_armed_cancel: assert property (p_armed_cancel) else $error("ninth clock not cancelled");

endmodule // ssr_eeprom_ctrl

// file: bench/ssr_host_model.sv
// Host serial controller model: select, clock and data in mode 0
module ssr_host_model (
  // Clock
  input  wire logic       clk,
  // Serial pins
  output logic            csN,
  output logic            sclk,
  output logic            mosi,
  input  wire logic       miso,
  input  wire logic       misoOe,
  // Received byte
  output logic            rxValid,
  output logic [7:0]      rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held;
  logic misoLine;
  assign misoLine = misoOe ? miso : ~held;
  always @(posedge clk) begin
    if (misoOe === 1'b1)
      held <= miso;
  end
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    held = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
  end
  // data set after fall, sampled at rise
  task automatic shift(input logic b, output logic r);
    mosi <= b;
    repeat (10) @(posedge clk);
    sclk <= 1'b1;
    r = misoLine;
    repeat (10) @(posedge clk);
    sclk <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic rep);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--)
      shift(tx[i], rx[i]);
    if (rep) begin
      rxByte <= rx;
      rxValid <= 1'b1;
      @(posedge clk);
      rxValid <= 1'b0;
    end
  endtask
  // every instruction starts with a select fall
  task automatic sel();
    csN <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // deselect before the next rising clock
  task automatic desel();
    repeat (10) @(posedge clk);
    csN <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
endmodule // ssr_host_model

// file: bench/ssr_eeprom_ctrl_tb.sv
// Self-checking bench for the serial EEPROM status and instruction logic
`include "ssr_regs.svh"
module ssr_eeprom_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NVM = 2000;
  logic        clk, rst, ce, wpN, csN, sclk, mosi, miso, misoOe, rxValid;
  logic        cmdArrayRead, cmdArrayWrite, arrayWriteReq, arrayWriteAck;
  logic        busyFlag, hardwareLockMode;
  logic [1:0]  blockProtect;
  logic [15:0] arrayWriteAddr;
  logic [7:0]  rxByte;
  logic [7:0]  expQ[$];
  logic [31:0] seed, r;
  int          num_errors, n_tests, cycles, nRd, nWr;
  //////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ssr_eeprom_ctrl #(.NVM_CYCLES(NVM)) u_ssr_eeprom_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .csN(csN), .sclk(sclk), .mosi(mosi), .wpN(wpN),
    .miso(miso), .misoOe(misoOe), .cmdArrayRead(cmdArrayRead),
    .cmdArrayWrite(cmdArrayWrite), .arrayWriteReq(arrayWriteReq),
    .arrayWriteAddr(arrayWriteAddr), .arrayWriteAck(arrayWriteAck),
    .busyFlag(busyFlag), .blockProtect(blockProtect),
    .hardwareLockMode(hardwareLockMode));
  ssr_host_model u_ssr_host_model (
    .clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso), .misoOe(misoOe),
    .rxValid(rxValid), .rxByte(rxByte));
  //////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t status byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input int nd, input int ex);
    logic b;
    u_ssr_host_model.sel();
    u_ssr_host_model.xfer(op, 1'b0);
    for (int i = 0; i < nd; i++)
      u_ssr_host_model.xfer(d, 1'b0);
    if (ex > 0)
      u_ssr_host_model.shift(1'b0, b);
    u_ssr_host_model.desel();
  endtask
  // Status read of two repeated bytes
  task automatic read_status(input logic [7:0] exp);
    u_ssr_host_model.sel();
    u_ssr_host_model.xfer(`SSR_READ_STATUS_CMD, 1'b0);
    repeat (2) begin
      expQ.push_back(exp);
      u_ssr_host_model.xfer(8'h00, 1'b1);
    end
    u_ssr_host_model.desel();
    chk_bit(misoOe, 1'b0);
  endtask
  task automatic awr(input logic [15:0] a, input logic exp);
    logic seen;
    seen = 1'b0;
    arrayWriteAddr <= a;
    arrayWriteReq <= 1'b1;
    @(posedge clk);
    arrayWriteReq <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      if (arrayWriteAck === 1'b1)
        seen = 1'b1;
    end
    chk_bit(seen, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busyFlag !== 1'b0 && n < 3 * NVM) begin
      @(posedge clk);
      n++;
    end
    chk_bit(busyFlag, 1'b0);
  endtask
  // Result monitor takes the oldest note
  always @(posedge clk) begin
    if (rxValid === 1'b1)
      chk_byte(expQ.pop_front(), rxByte);
  end
  // Array hand-off pulses counted
  always @(posedge clk) begin
    if (cmdArrayRead === 1'b1)
      nRd++;
    if (cmdArrayWrite === 1'b1)
      nWr++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("BAD %0t run did not finish", $time);
      results();
    end
  end
  //////////////////////////////////////////////
  initial begin
    seed = 32'h0000BD5C;
    {num_errors, n_tests, cycles, nRd, nWr} = '0;
    rst = 1'b1;
    ce = 1'b1;
    wpN = 1'b1;
    arrayWriteReq = 1'b0;
    arrayWriteAddr = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(busyFlag | hardwareLockMode | misoOe | (|blockProtect), 1'b0);
    read_status(8'h00);
    frame(`SSR_READ_ARRAY_CMD, 8'h00, 0, 0);
    frame(`SSR_WRITE_ARRAY_CMD, 8'h00, 0, 0);
    chk_bit(nRd == 1 && nWr == 1, 1'b1);
    u_ssr_host_model.sel();
    u_ssr_host_model.xfer(8'hFF, 1'b0);
    u_ssr_host_model.xfer(`SSR_READ_STATUS_CMD, 1'b0);
    chk_bit(misoOe, 1'b0);
    u_ssr_host_model.xfer(`SSR_SET_WRITE_LATCH_CMD, 1'b0);
    u_ssr_host_model.desel();
    read_status(8'h00);
    frame(`SSR_WRITE_STATUS_CMD, 8'h8C, 1, 0);
    read_status(8'h00);
    frame(`SSR_SET_WRITE_LATCH_CMD, 8'h00, 0, 0);
    read_status(8'h02);
    frame(`SSR_CLEAR_WRITE_LATCH_CMD, 8'h00, 0, 0);
    read_status(8'h00);
    frame(`SSR_SET_WRITE_LATCH_CMD, 8'h00, 0, 0);
    r = xs();
    frame(`SSR_WRITE_STATUS_CMD, r[7:0], 1, 1);
    read_status(8'h02);
    frame(`SSR_WRITE_STATUS_CMD, 8'hFF, 1, 0);
    read_status(8'h03);
    chk_bit(|blockProtect, 1'b0);
    wait_idle();
    read_status(8'h8C);
    chk_bit(&blockProtect, 1'b1);
    frame(`SSR_SET_WRITE_LATCH_CMD, 8'h00, 0, 0);
    r = xs();
    awr(r[15:0], 1'b0);
    read_status(8'h8E);
    wpN <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit(hardwareLockMode, 1'b1);
    frame(`SSR_WRITE_STATUS_CMD, 8'h00, 1, 0);
    chk_bit(busyFlag, 1'b0);
    read_status(8'h8E);
    wpN <= 1'b1;
    repeat (8) @(posedge clk);
    frame(`SSR_WRITE_STATUS_CMD, 8'h04, 1, 0);
    wait_idle();
    read_status(8'h04);
    frame(`SSR_SET_WRITE_LATCH_CMD, 8'h00, 0, 0);
    r = xs();
    awr(r[15:0] | 16'hC000, 1'b0);
    awr(r[15:0] & 16'hBFFF, 1'b1);
    chk_bit(busyFlag, 1'b1);
    frame(`SSR_READ_ARRAY_CMD, 8'h00, 0, 0);
    chk_bit(nRd == 1, 1'b1);
    // Enable low must freeze the write cycle
    ce <= 1'b0;
    repeat (NVM + 10) @(posedge clk);
    chk_bit(busyFlag, 1'b1);
    ce <= 1'b1;
    wait_idle();
    read_status(8'h04);
    results();
  end
endmodule // ssr_eeprom_ctrl_tb
